// ### evs_pkg.sv
// constants, types and register map of the exception vector sequencer
package evs_pkg;

    // vector numbers
    localparam logic [7:0] VEC_RESET_SP   = 8'h00;
    localparam logic [7:0] VEC_RESET_PC   = 8'h01;
    localparam logic [7:0] VEC_BUS_ERR    = 8'h02;
    localparam logic [7:0] VEC_ADDR_ERR   = 8'h03;
    localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
    localparam logic [7:0] VEC_ZERO_DIV   = 8'h05;
    localparam logic [7:0] VEC_BOUND      = 8'h06;
    localparam logic [7:0] VEC_CONDITIONAL_TRAP_INSTR     = 8'h07;
    localparam logic [7:0] VEC_PRIV       = 8'h08;
    localparam logic [7:0] VEC_TRACE      = 8'h09;
    localparam logic [7:0] VEC_LINE_A     = 8'h0A;
    localparam logic [7:0] VEC_LINE_F     = 8'h0B;
    localparam logic [7:0] VEC_HW_BREAKPOINT_OPCODE    = 8'h0C;
    localparam logic [7:0] VEC_FORMAT     = 8'h0E;
    localparam logic [7:0] VEC_SPURIOUS   = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE  = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE  = 8'h20;
    localparam logic [7:0] VEC_USER_FIRST = 8'h40;
    localparam int         TABLE_BYTES    = 1024;
    localparam int         TABLE_ENTRIES  = 256;

    // function codes of the bus
    localparam logic [2:0] FC_SUP_DATA = 3'h5;
    localparam logic [2:0] FC_SUP_PROG = 3'h6;
    localparam logic [2:0] FC_CPU      = 3'h7;
    localparam logic [3:0] IACK_CYCLE  = 4'hF;

    // status word fields
    localparam int         PSW_T1   = 15;
    localparam int         PSW_T0   = 14;
    localparam int         PSW_S    = 13;
    localparam int         PSW_MASK = 8;
    localparam logic [15:0] PSW_RESET = 16'h2700;
    localparam logic [3:0]  FRAME_FORMAT = 4'h0;

    // opcode patterns
    localparam logic [3:0]  LINE_A_NIB   = 4'hA;
    localparam logic [3:0]  LINE_F_NIB   = 4'hF;
    localparam logic [12:0] BREAKPOINT_OPCODE_OP_HIGH = 13'h0909;

    // register byte offsets
    localparam logic [4:0] REG_VTB    = 5'h00;
    localparam logic [4:0] REG_PSW    = 5'h04;
    localparam logic [4:0] REG_SSP    = 5'h08;
    localparam logic [4:0] REG_CTRL   = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_HPC    = 5'h14;
    localparam logic [31:0] VTB_RESET = 32'h0000_0000;
    localparam logic [31:0] SSP_RESET = 32'h0000_0000;
    localparam int          CTRL_DBG  = 0;

    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001,
        S_IACK  = 7'b0000010,
        S_PSH_FV = 7'b0000100,
        S_PSH_PC = 7'b0001000,
        S_PSH_SR = 7'b0010000,
        S_FETCH = 7'b0100000,
        S_LOAD  = 7'b1000000
    } evs_state_t;

    // core event pulses, one cycle each
    typedef struct packed {
        logic        bus_error;
        logic        address_error;
        logic        illegal_opcode;
        logic [15:0] opcode;
        logic        zero_divide;
        logic        bound_check;
        logic        conditional_trap;
        logic        overflow_trap;
        logic        privilege;
        logic        trap_instr;
        logic [3:0]  trap_num;
        logic        format_error;
        logic        instr_done;
        logic        flow_change;
    } evs_event_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        long_word;
        logic [2:0]  space;
        logic [31:0] addr;
        logic [31:0] wdata;
    } evs_sb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic        autovec;
        logic [31:0] rdata;
    } evs_sb_rsp_t;

endpackage

// ### evs_exception_vector_sequencer.sv
// exception vector sequencer: vector numbering, frame push and vector fetch
//
// Local design decisions: register access over Avalon-MM and the register addresses.
module evs_exception_vector_sequencer
    import evs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire evs_event_t  event_i,
    input  wire logic [31:0] pc_i,
    input  wire logic [2:0]  irq_level_n_i,
    input  wire logic        breakpoint_opcode_n_i,
    output evs_sb_req_t      sb_req_o,
    input  wire evs_sb_rsp_t sb_rsp_i,
    output logic      [15:0] psw_o,
    output logic      [31:0] handler_pc_o,
    output logic             handler_go_o,
    output logic             busy_o,
    output logic             debug_request_o
);

    typedef struct packed {
        evs_state_t  fsm;
        logic [31:0] vtb;
        logic [15:0] psw;
        logic [15:0] saved_psw;
        logic [31:0] ssp;
        logic        debug_en;
        logic        p_buserr;
        logic        p_addrerr;
        logic        p_instr;
        logic [7:0]  instr_vec;
        logic        p_trace;
        logic        p_breakpoint_opcode;
        logic [7:0]  vec;
        logic [2:0]  irq_lvl;
        logic [31:0] saved_pc;
        evs_sb_req_t sb;
        logic [31:0] handler_pc;
        logic        go;
        logic        dbg_req;
        logic        brk_op;
        logic [2:0]  irq_s1;
        logic [2:0]  irq_s2;
        logic [2:0]  irq_s3;
        logic [2:0]  irq_f;
        logic        bk_s1;
        logic        bk_s2;
        logic        bk_s3;
        logic        bk_f;
        logic        nmi_done;
        logic        served;
        logic [31:0] rdata;
    } evs_st_t;

    evs_st_t st;
    evs_st_t next_st;

    logic        irq_take;
    logic [7:0]  ev_vec;
    logic        ev_instr;
    logic        any_pending;
    logic [31:0] reg_rd;
    logic [31:0] be_mask;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st.served;
    assign avs_readdata_o    = st.rdata;
    assign sb_req_o          = st.sb;
    assign psw_o             = st.psw;
    assign handler_pc_o      = st.handler_pc;
    assign handler_go_o      = st.go;
    assign busy_o            = st.fsm != S_IDLE;
    assign debug_request_o   = st.dbg_req;

    // byte lanes widened to bit masks for partial register writes
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // level 7 cannot be masked; it is taken once per assertion
    assign irq_take = (st.irq_f != 3'h0)
                    && ((st.irq_f > st.psw[PSW_MASK +: 3])
                        || (st.irq_f == 3'h7 && !st.nmi_done));

    // internal vector numbers; only listed sources, reserved ones never appear
    always_comb
    begin
        ev_instr = 1'b1;
        // internal sources stay below 64; higher numbers only come from devices
        ev_vec   = VEC_ILLEGAL;
        if (event_i.illegal_opcode)
        begin
            if (event_i.opcode[15:12] == LINE_A_NIB)
                ev_vec = VEC_LINE_A;
            else if (event_i.opcode[15:12] == LINE_F_NIB)
                ev_vec = VEC_LINE_F;
            else
                ev_vec = VEC_ILLEGAL;
        end
        else if (event_i.privilege)
            ev_vec = VEC_PRIV;
        else if (event_i.trap_instr)
            ev_vec = VEC_TRAP_BASE + {4'h0, event_i.trap_num};
        else if (event_i.conditional_trap || event_i.overflow_trap)
            ev_vec = VEC_CONDITIONAL_TRAP_INSTR;
        else if (event_i.bound_check)
            ev_vec = VEC_BOUND;
        else if (event_i.zero_divide)
            ev_vec = VEC_ZERO_DIV;
        else if (event_i.format_error)
            ev_vec = VEC_FORMAT;
        else
            ev_instr = 1'b0;
    end

    // read mux; latched when a request is first seen, so readdata comes from a flop
    always_comb
    begin
        reg_rd = 32'h0000_0000;
        unique case (avs_address_i)
            REG_VTB:    reg_rd = st.vtb;
            REG_PSW:    reg_rd = {16'h0000, st.psw};
            REG_SSP:    reg_rd = st.ssp;
            REG_CTRL:   reg_rd = {31'h0000_0000, st.debug_en};
            REG_STATUS: reg_rd = {16'h0000, st.brk_op, st.p_buserr, st.p_addrerr,
                                  st.p_instr, st.p_trace, st.p_breakpoint_opcode, busy_o,
                                  1'b0, st.vec};
            REG_HPC:    reg_rd = st.handler_pc;
            default:    reg_rd = 32'h0000_0000;
        endcase
    end

    // anything that would open a new sequence from idle
    assign any_pending = st.p_buserr | st.p_addrerr | st.p_instr | st.p_trace
                       | st.p_breakpoint_opcode | irq_take;

    always_comb
    begin
        next_st         = st;
        next_st.go      = 1'b0;
        next_st.dbg_req = 1'b0;

        // three-stage pin sampling, accept once stages two and three agree
        next_st.irq_s1 = ~irq_level_n_i;
        next_st.irq_s2 = st.irq_s1;
        next_st.irq_s3 = st.irq_s2;
        if (st.irq_s2 == st.irq_s3)
            next_st.irq_f = st.irq_s3;
        next_st.bk_s1 = breakpoint_opcode_n_i;
        next_st.bk_s2 = st.bk_s1;
        next_st.bk_s3 = st.bk_s2;
        if (st.bk_s2 == st.bk_s3)
            next_st.bk_f = st.bk_s3;
        if (st.irq_f != 3'h7)
            next_st.nmi_done = 1'b0;

        // register bus: accept one cycle after the request, answer from flops
        next_st.served = (avs_read_i | avs_write_i) & ~st.served;
        if ((avs_read_i | avs_write_i) && !st.served)
            next_st.rdata = reg_rd;
        if (avs_write_i && st.served)
        begin
            unique case (avs_address_i)
                REG_VTB:
                    next_st.vtb = (st.vtb & ~be_mask) | (avs_writedata_i & be_mask);
                REG_PSW:
                    next_st.psw = (st.psw & ~be_mask[15:0])
                                | (avs_writedata_i[15:0] & be_mask[15:0]);
                REG_SSP:
                    next_st.ssp = (st.ssp & ~be_mask) | (avs_writedata_i & be_mask);
                REG_CTRL:
                    if (avs_byteenable_i[0])
                        next_st.debug_en = avs_writedata_i[CTRL_DBG];
                default:
                    next_st.ssp = next_st.ssp;
            endcase
        end

        // sticky pending flags, cleared below when taken; a fresh event re-sets
        if (event_i.illegal_opcode && event_i.opcode[15:3] == BREAKPOINT_OPCODE_OP_HIGH)
            next_st.brk_op = 1'b1;

        unique case (st.fsm)
            S_IDLE:
            begin
                if (any_pending)
                begin
                    next_st.saved_psw    = st.psw;
                    next_st.psw[PSW_S]   = 1'b1;
                    next_st.psw[PSW_T1]  = 1'b0;
                    next_st.psw[PSW_T0]  = 1'b0;
                    next_st.saved_pc     = pc_i;
                    next_st.fsm          = S_PSH_FV;
                    // fixed priority: bus, address, instruction, trace, pin, interrupt
                    if (st.p_buserr)
                    begin
                        next_st.vec      = VEC_BUS_ERR;
                        next_st.p_buserr = 1'b0;
                    end
                    else if (st.p_addrerr)
                    begin
                        next_st.vec       = VEC_ADDR_ERR;
                        next_st.p_addrerr = 1'b0;
                    end
                    else if (st.p_instr)
                    begin
                        next_st.vec     = st.instr_vec;
                        next_st.p_instr = 1'b0;
                    end
                    else if (st.p_trace)
                    begin
                        next_st.vec     = VEC_TRACE;
                        next_st.p_trace = 1'b0;
                    end
                    else if (st.p_breakpoint_opcode)
                    begin
                        next_st.vec    = VEC_HW_BREAKPOINT_OPCODE;
                        next_st.p_breakpoint_opcode = 1'b0;
                    end
                    else
                    begin
                        next_st.irq_lvl            = st.irq_f;
                        next_st.psw[PSW_MASK +: 3] = st.irq_f;
                        next_st.nmi_done           = st.irq_f == 3'h7;
                        next_st.fsm                = S_IACK;
                    end
                end
            end
            S_IACK:
            begin
                if (!st.sb.req)
                begin
                    next_st.sb.req       = 1'b1;
                    next_st.sb.we        = 1'b0;
                    next_st.sb.long_word = 1'b0;
                    next_st.sb.space     = FC_CPU;
                    next_st.sb.addr      = {12'h000, IACK_CYCLE, 12'h000, st.irq_lvl, 1'b1};
                end
                else if (sb_rsp_i.ack)
                begin
                    next_st.sb.req = 1'b0;
                    next_st.fsm    = S_PSH_FV;
                    // a refused acknowledge is spurious; autovectors map locally
                    if (sb_rsp_i.err)
                        next_st.vec = VEC_SPURIOUS;
                    else if (sb_rsp_i.autovec)
                        next_st.vec = VEC_AUTO_BASE + {5'h00, st.irq_lvl};
                    else
                        next_st.vec = sb_rsp_i.rdata[7:0];
                end
            end
            S_PSH_FV, S_PSH_PC, S_PSH_SR:
            begin
                if (!st.sb.req)
                begin
                    next_st.sb.req   = 1'b1;
                    next_st.sb.we    = 1'b1;
                    next_st.sb.space = FC_SUP_DATA;
                    // pre-decrement: format word, then pc, then status word on top
                    if (st.fsm == S_PSH_PC)
                    begin
                        next_st.ssp          = st.ssp - 32'h0000_0004;
                        next_st.sb.long_word = 1'b1;
                        next_st.sb.wdata     = st.saved_pc;
                    end
                    else
                    begin
                        next_st.ssp          = st.ssp - 32'h0000_0002;
                        next_st.sb.long_word = 1'b0;
                        next_st.sb.wdata     = (st.fsm == S_PSH_SR)
                            ? {16'h0000, st.saved_psw}
                            : {16'h0000, FRAME_FORMAT, 2'b00, st.vec, 2'b00};
                    end
                    next_st.sb.addr = next_st.ssp;
                end
                else if (sb_rsp_i.ack)
                begin
                    next_st.sb.req = 1'b0;
                    unique case (st.fsm)
                        S_PSH_FV: next_st.fsm = S_PSH_PC;
                        S_PSH_PC: next_st.fsm = S_PSH_SR;
                        default:  next_st.fsm = S_FETCH;
                    endcase
                end
            end
            S_FETCH:
            begin
                if (!st.sb.req)
                begin
                    next_st.sb.req       = 1'b1;
                    next_st.sb.we        = 1'b0;
                    next_st.sb.long_word = 1'b1;
                    next_st.sb.space     = FC_SUP_DATA;
                    // an 8-bit number times four never leaves the table
                    next_st.sb.addr      = st.vtb + {22'h000000, st.vec, 2'b00};
                end
                else if (sb_rsp_i.ack)
                begin
                    // a failed fetch still loads; its error response sets no pending flag here
                    next_st.sb.req     = 1'b0;
                    next_st.handler_pc = sb_rsp_i.rdata;
                    next_st.fsm        = S_LOAD;
                end
            end
            S_LOAD:
            begin
                // withhold the resume pulse so a waiting exception is served first
                next_st.go  = ~any_pending;
                next_st.fsm = S_IDLE;
            end
        endcase

        // event capture after the clears above, so a new event wins
        if (event_i.bus_error)
            next_st.p_buserr = 1'b1;
        if (event_i.address_error)
            next_st.p_addrerr = 1'b1;
        if (ev_instr)
        begin
            next_st.p_instr   = 1'b1;
            next_st.instr_vec = ev_vec;
        end
        if (event_i.instr_done
            && ((st.psw[PSW_T1] && !st.psw[PSW_T0])
                || (!st.psw[PSW_T1] && st.psw[PSW_T0] && event_i.flow_change)))
            next_st.p_trace = 1'b1;

        // pin breakpoint captured after the clears, so a same-cycle edge is kept
        if (st.bk_f && !next_st.bk_f)
        begin
            if (st.debug_en)
                next_st.dbg_req = 1'b1;
            else
                next_st.p_breakpoint_opcode = 1'b1;
        end
    end

    // reset wins over the clock enable
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st          <= '0;
            st.fsm      <= S_IDLE;
            st.psw      <= PSW_RESET;
            st.vtb      <= VTB_RESET;
            st.ssp      <= SSP_RESET;
            st.bk_s1    <= 1'b1;
            st.bk_s2    <= 1'b1;
            st.bk_s3    <= 1'b1;
            st.bk_f     <= 1'b1;
        end
        else if (ce_i)
        begin
            st <= next_st;
        end
    end

endmodule

// ### evs_bus_model.sv
// system bus partner: vector memory and interrupting peripheral
module evs_bus_model
    import evs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        slow_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [7:0]  vec_i,
    input  wire evs_sb_req_t sb_req_i,
    output evs_sb_rsp_t      sb_rsp_o
);
    logic [1:0] dly;

    initial sb_rsp_o = '0;

    always @(posedge clk_i)
    begin
        sb_rsp_o.ack <= 1'b0;
        sb_rsp_o.err <= 1'b0;
        sb_rsp_o.autovec <= 1'b0;
        // data lines invert every cycle between answers instead of holding the last value
        sb_rsp_o.rdata <= ~sb_rsp_o.rdata;
        if (reset_i)
            dly <= 2'h0;
        else if (sb_req_i.req && !sb_rsp_o.ack)
        begin
            if (dly != 2'h0)
                dly <= dly - 2'h1;
            else
            begin
                sb_rsp_o.ack <= 1'b1;
                dly <= slow_i ? 2'($urandom_range(3, 1)) : 2'h0;
                if (sb_req_i.space == FC_CPU)
                begin
                    sb_rsp_o.rdata <= {24'h0, vec_i};
                    sb_rsp_o.autovec <= mode_i == 2'h1;
                    sb_rsp_o.err <= mode_i == 2'h2;
                end
                else
                    sb_rsp_o.rdata <= {sb_req_i.addr[15:0], ~sb_req_i.addr[15:0]};
            end
        end
    end
endmodule

// ### evs_exception_vector_sequencer_chk.sv
// port checker of the exception vector sequencer
module evs_chk
    import evs_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire evs_sb_req_t sb_req_o,
    input wire evs_sb_rsp_t sb_rsp_i,
    input wire logic [15:0] psw_o,
    input wire logic        busy_o,
    input wire logic        handler_go_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_fmt_push;
        sb_req_o.req && sb_req_o.we && !sb_req_o.long_word && sb_req_o.wdata[15:12] == 4'h0;
    endsequence
    sequence s_iack;
        sb_req_o.req && sb_req_o.space == FC_CPU;
    endsequence

    property p_frame; $rose(busy_o) |-> ##[1:60] s_fmt_push; endproperty
    a_frame: assert property (p_frame) else $error("frame push missing");
    property p_iack; s_iack |-> !sb_req_o.we && sb_req_o.addr[19:16] == IACK_CYCLE; endproperty
    a_iack: assert property (p_iack) else $error("bad acknowledge cycle");
    property p_mask; s_iack |-> psw_o[10:8] == sb_req_o.addr[3:1]; endproperty
    a_mask: assert property (p_mask) else $error("mask not updated");
    property p_entry; $rose(busy_o) |-> psw_o[PSW_S] && psw_o[15:14] == 2'b00; endproperty
    a_entry: assert property (p_entry) else $error("entry status wrong");
    property p_hold; sb_req_o.req && !sb_rsp_i.ack |=> $stable(sb_req_o); endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    property p_fetch;
        sb_req_o.req && !sb_req_o.we && sb_req_o.space == FC_SUP_DATA
            |-> sb_req_o.long_word && sb_req_o.addr[1:0] == 2'b00;
    endproperty
    a_fetch: assert property (p_fetch) else $error("vector fetch shape");
    property p_space; sb_req_o.req && sb_req_o.we |-> sb_req_o.space == FC_SUP_DATA; endproperty
    a_space: assert property (p_space) else $error("push outside data space");
    property p_go; handler_go_o |-> $past(busy_o) && !$past(handler_go_o); endproperty
    a_go: assert property (p_go) else $error("resume without sequence");
endmodule

bind evs_exception_vector_sequencer evs_chk i_chk (.clk_i, .reset_i, .sb_req_o, .sb_rsp_i,
    .psw_o, .busy_o, .handler_go_o);

// ### evs_exception_vector_sequencer_test.sv
// self-checking bench of the exception vector sequencer
module evs_exception_vector_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import evs_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end

    logic        clk_i, reset_i, rd, wr, breakpoint_opcode_n, slow, go, busy, dbg, wtq;
    logic [4:0]  adr;
    logic [31:0] wdat, rdat, pc, vtb, q, hpc, la;
    logic [2:0]  irq_n;
    logic [1:0]  mode;
    logic [7:0]  ivec;
    logic [15:0] psw;
    evs_event_t  ev;
    evs_sb_req_t req;
    evs_sb_rsp_t rsp;
    logic [31:0] wd[$];
    logic [7:0]  vt[12] = '{8'd2, 8'd3, 8'd5, 8'd6, 8'd7, 8'd7, 8'd8, 8'd14, 8'd4, 8'd10,
                            8'd11, 8'd4};
    int          bad_count, cmp_count, cyc;

    evs_exception_vector_sequencer i_dut (.clk_i, .reset_i, .ce_i(1'b1), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wtq), .event_i(ev), .pc_i(pc),
        .irq_level_n_i(irq_n), .breakpoint_opcode_n_i(breakpoint_opcode_n), .sb_req_o(req), .sb_rsp_i(rsp), .psw_o(psw),
        .handler_pc_o(hpc), .handler_go_o(go), .busy_o(busy), .debug_request_o(dbg));
    evs_bus_model i_bus (.clk_i, .reset_i, .slow_i(slow), .mode_i(mode), .vec_i(ivec),
        .sb_req_i(req), .sb_rsp_o(rsp));

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // stack writes seen by the bench, one entry per accepted push
    always @(posedge clk_i)
    begin
        cyc++;
        if (req.req && rsp.ack && req.we)
        begin
            wd.push_back(req.wdata);
            la = req.addr;
        end
        if (cyc == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        // waitrequest and readdata are taken at the rising edge that ends the cycle
        do
            @(posedge clk_i);
        while (wtq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // l[2:0] interrupt level, l[3] breakpoint pin
    task exc(input evs_event_t e, input logic [7:0] v, input logic [15:0] s, input logic [3:0] l);
        logic [31:0] a;
        bus(1'b1, REG_PSW, {16'h0, s});
        bus(1'b1, REG_SSP, 32'h1000);
        a = vtb + {22'h0, v, 2'b00};
        wd.delete();
        pc <= $urandom & 32'hFFFF_FFFE;
        ev <= e;
        irq_n <= ~l[2:0];
        breakpoint_opcode_n <= !l[3];
        @(posedge clk_i);
        ev <= '0;
        for (int n = 0; n < 300 && go !== 1'b1; n++)
            @(negedge clk_i);
        `CHK(go, 1'b1)
        `CHK(hpc, {a[15:0], ~a[15:0]})
        `CHK(wd.size(), 3)
        `CHK(wd[0][15:0], {6'h0, v, 2'b00})
        `CHK(wd[1], pc)
        `CHK(wd[2][15:0], s)
        `CHK(la, 32'h0000_0FF8)
        `CHK(psw[15:13], 3'b001)
        if (l[2:0] != 3'h0)
            `CHK(psw[10:8], l[2:0])
        bus(1'b0, REG_STATUS, 32'h0);
        `CHK(q[7:0], v)
        bus(1'b0, REG_HPC, 32'h0);
        `CHK(q, {a[15:0], ~a[15:0]})
        @(posedge clk_i);
        irq_n <= 3'h7;
        breakpoint_opcode_n <= 1'b1;
        $display("vector %0d done", v);
    endtask

    initial
    begin
        evs_event_t  e;
        logic [31:0] r;
        logic [2:0]  lv;
        {reset_i, rd, wr, adr, wdat, ev, pc, irq_n, breakpoint_opcode_n, slow, mode, ivec} = '0;
        reset_i = 1'b1;
        irq_n = 3'h7;
        breakpoint_opcode_n = 1'b1;
        void'($urandom(32'h5bd2));
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        bus(1'b0, REG_PSW, 32'h0);
        `CHK(q[15:0], PSW_RESET)
        bus(1'b0, 5'h18, 32'h0);
        `CHK(q, 32'h0)
        vtb = $urandom & 32'h00FF_FFFC;
        bus(1'b1, REG_VTB, vtb);
        bus(1'b0, REG_VTB, 32'h0);
        `CHK(q, vtb)
        $display("register access done");
        for (int k = 0; k < 12; k++)
        begin
            e = '0;
            r = $urandom;
            slow <= k[0];
            case (k)
                0: e.bus_error = 1'b1;
                1: e.address_error = 1'b1;
                2: e.zero_divide = 1'b1;
                3: e.bound_check = 1'b1;
                4: e.conditional_trap = 1'b1;
                5: e.overflow_trap = 1'b1;
                6: e.privilege = 1'b1;
                7: e.format_error = 1'b1;
                default: e.illegal_opcode = 1'b1;
            endcase
            e.opcode = k == 8 ? 16'h4AFC : k == 9 ? {LINE_A_NIB, r[11:0]}
                : k == 10 ? {LINE_F_NIB, r[11:0]} : {BREAKPOINT_OPCODE_OP_HIGH, r[2:0]};
            exc(e, vt[k], 16'(r[4:0]), 4'h0);
        end
        for (int n = 0; n < 16; n++)
        begin
            e = '0;
            e.trap_instr = 1'b1;
            e.trap_num = n[3:0];
            exc(e, 8'h20 + 8'(n), 16'($urandom_range(31)), 4'h0);
        end
        e = '0;
        e.instr_done = 1'b1;
        exc(e, VEC_TRACE, 16'h8000, 4'h0);
        e.flow_change = 1'b1;
        exc(e, VEC_TRACE, 16'h4000, 4'h0);
        for (int m = 0; m < 3; m++)
        begin
            lv = 3'($urandom_range(7, 1));
            mode <= m[1:0];
            ivec <= 8'h40 + 8'($urandom_range(191));
            @(posedge clk_i);
            exc('0, m == 0 ? ivec : m == 1 ? 8'd24 + 8'(lv) : 8'd24, 16'h0, {1'b0, lv});
        end
        bus(1'b1, REG_CTRL, 32'h0);
        exc('0, VEC_HW_BREAKPOINT_OPCODE, 16'h0, 4'h8);
        bus(1'b1, REG_CTRL, 32'h1);
        breakpoint_opcode_n <= 1'b0;
        for (int n = 0; n < 20 && dbg !== 1'b1; n++)
            @(negedge clk_i);
        `CHK(dbg, 1'b1)
        `CHK(busy, 1'b0)
        $display("debug request done");
        wrap_up();
    end
endmodule
